// file: hdl/cmd_pkg.sv
/*
 * Shared constants and types for the command frame interpreter.
 * Assumes a 50 MHz clock and byte-wide, same-clock link logic.
 */
package cmd_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ      = 50;
    localparam int IDLE_TIME_US = 5000;
    localparam int IDLE_CYCLES  = IDLE_TIME_US * CLK_MHZ;

    // ****************************************************************
    // Frame geometry
    // ****************************************************************
    localparam logic [3:0] SER_LAST_IDX = 4'h8;
    localparam logic [3:0] CAN_LAST_IDX = 4'h6;
    localparam logic [3:0] SER_REPLY_LEN = 4'h9;
    localparam logic [3:0] CAN_REPLY_LEN = 4'h7;

    // ****************************************************************
    // Instructions, setting numbers and status codes
    // ****************************************************************
    localparam logic [7:0] INSTR_SET_AXIS = 8'h05;
    localparam logic [7:0] INSTR_GET_AXIS = 8'h06;
    localparam logic [7:0] SET_MAX_SPEED  = 8'h04;
    localparam logic [7:0] SET_MAX_ACCEL  = 8'h05;
    localparam logic [7:0] SET_RUN_CUR    = 8'h06;
    localparam logic [7:0] SET_STBY_CUR   = 8'h07;
    localparam logic [7:0] AXIS_ZERO      = 8'h00;
    localparam logic [7:0] STAT_OK        = 8'h64;
    localparam logic [7:0] STAT_BAD_SUM   = 8'h01;
    localparam logic [7:0] STAT_BAD_INSTR = 8'h02;
    localparam logic [7:0] STAT_BAD_TYPE  = 8'h03;
    localparam logic [7:0] STAT_BAD_VALUE = 8'h04;

    // ****************************************************************
    // Setting limits and reset values
    // ****************************************************************
    localparam logic [31:0] RAMP_MIN    = 32'h0000_0001;
    localparam logic [31:0] RAMP_MAX    = 32'h0000_07ff;
    localparam logic [31:0] CURRENT_MAX = 32'h0000_00ff;
    localparam logic [10:0] RST_MAX_SPEED = 11'h0c8;
    localparam logic [10:0] RST_MAX_ACCEL = 11'h064;
    localparam logic [7:0]  RST_RUN_CUR   = 8'h80;
    localparam logic [7:0]  RST_STBY_CUR  = 8'h20;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  instr;
        logic [7:0]  typ;
        logic [7:0]  sel;
        logic [31:0] value;
    } cmd_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  instr;
        logic [31:0] value;
    } reply_t;

    typedef struct packed {
        logic [10:0] max_speed;
        logic [10:0] max_accel;
        logic [7:0]  run_current;
        logic [7:0]  standby_current;
    } settings_t;

    typedef enum logic [1:0] {
        S_RECV  = 2'b00,
        S_EXEC  = 2'b01,
        S_REPLY = 2'b11
    } fsm_t;

endpackage

// file: hdl/reply_serializer.sv
/*
 * Reply byte serializer: frames one reply and hands it out byte by byte.
 * Assumes a start pulse only while idle and a same-clock transmitter.
 */
`timescale 1ns/10ps
module reply_serializer
    import cmd_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            arst_n,
    input  wire logic            ce,
    input  wire logic            start,
    input  wire logic            can_mode,
    input  wire logic [7:0]      reply_addr,
    input  wire logic [7:0]      node_addr,
    input  wire cmd_pkg::reply_t reply,
    input  wire logic            tx_ready,
    output logic                 tx_valid,
    output logic [7:0]           tx_data,
    output logic                 tx_last,
    output logic                 tx_drive,
    output logic                 done
);
    logic [71:0] buf_reg;
    logic [3:0]  left_reg;
    logic        valid_reg;
    logic        last_reg;
    logic        done_reg;
    logic [71:0] image;
    logic        take;

    function automatic logic [7:0] sum8(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + b[i*8 +: 8];
        end
        return s;
    endfunction

    // ****************************************************************
    // Reply image
    // ****************************************************************
    always_comb begin
        if (can_mode) begin
            image = {node_addr, reply, 16'h0000};
        end else begin
            image = {reply_addr, node_addr, reply, 8'h00};
            image[7:0] = sum8(image[71:8]);
        end
    end

    assign take = valid_reg && tx_ready;

    // ****************************************************************
    // Shifter
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_reg   <= '0;
            left_reg  <= 4'h0;
            valid_reg <= 1'b0;
            last_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else if (ce) begin
            done_reg <= 1'b0;
            if (start) begin
                buf_reg   <= image;
                left_reg  <= can_mode ? CAN_REPLY_LEN : SER_REPLY_LEN;
                valid_reg <= 1'b1;
                last_reg  <= 1'b0;
            end else if (take) begin
                buf_reg  <= {buf_reg[63:0], 8'h00};
                left_reg <= left_reg - 4'h1;
                last_reg <= (left_reg == 4'h3) ? 1'b0 : (left_reg == 4'h2);
                if (last_reg) begin
                    valid_reg <= 1'b0;
                    done_reg  <= 1'b1;
                end
            end
        end
    end

    assign tx_valid = valid_reg;
    assign tx_drive = valid_reg;
    assign tx_data  = buf_reg[71:64];
    assign tx_last  = last_reg;
    assign done     = done_reg;
endmodule

// file: hdl/serial_command_frame_interpreter.sv
/*
 * Command frame interpreter: assembles host frames, checks them, runs the
 * axis-setting commands and answers once per command.
 * Assumes rx bytes, program commands and tx handshake come from logic on clk.
 */
// Behaviour
// - A command is seven bytes: instruction, type, selector, four value bytes.
// - Serial and USB frames add a leading address and trailing checksum.
// - Byte order: address, instruction, type, selector, value MSB first, checksum.
// - Checksum is the 8-bit sum of all earlier frame bytes; device checks it.
// - CAN frames carry no address byte and no checksum byte.
// - Over CAN the message identifier decides whether the command is ours.
// - All actions of a command complete before its reply goes out.
// - Device listens except while replying; never transmits unsolicited.
// - The same commands are accepted from the host and the stored program.
// - Setting 6 holds running current, 0 to 255, 255 is full current.
// - Setting 7 holds standstill current, 0 to 255, 255 is full current.
// - Setting 4 holds peak positioning speed, readable, writable, at most 2047.
// - Setting 5 holds acceleration limit, same range, also velocity-mode ramp.
// - Set-setting: type is setting number, selector the axis, value the data.
// - Serial reply: reply address, node, status, instruction, value, checksum.
// - Status 100 ok, 1 checksum, 2 instruction, 3 type, 4 value.
// - CAN reply drops address and checksum, identifier is the reply address (code sends can_node_id).
`timescale 1ns/10ps
module serial_command_frame_interpreter
    import cmd_pkg::*;
#(
    parameter int IDLE_LIMIT = cmd_pkg::IDLE_CYCLES
)
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               ce,
    input  wire logic               can_mode,
    input  wire logic [7:0]         node_addr,
    input  wire logic [7:0]         reply_addr,
    input  wire logic [10:0]        can_node_id,
    input  wire logic               link_reset,
    input  wire logic               rx_valid,
    input  wire logic [7:0]         rx_data,
    input  wire logic [10:0]        rx_can_id,
    input  wire logic               prog_valid,
    input  wire cmd_pkg::cmd_t      prog_cmd,
    output logic                    prog_ready,
    output logic                    prog_done,
    output cmd_pkg::reply_t         prog_reply,
    input  wire logic               tx_ready,
    output logic                    tx_valid,
    output logic [7:0]              tx_data,
    output logic                    tx_last,
    output logic                    tx_drive,
    output logic [10:0]             tx_can_id,
    output cmd_pkg::settings_t      settings
);
    import cmd_pkg::*;

    fsm_t        state_reg;
    fsm_t        state_next;
    cmd_t        frame_reg;
    logic [3:0]  cnt_reg;
    logic [7:0]  sum_reg;
    logic        mine_reg;
    logic        bad_sum_reg;
    logic        host_reg;
    logic [31:0] idle_reg;
    logic        fire;
    logic        take_prog;
    logic        take_byte;
    logic        is_addr;
    logic        is_sum;
    logic        is_last;
    logic        abort;
    logic        ser_done;
    logic        ser_start;
    reply_t      result;
    logic        wr_ok;
    logic        prog_ready_reg;
    logic        prog_done_reg;
    reply_t      prog_reply_reg;
    settings_t   set_reg;
    logic [10:0] can_id_reg;

    // ****************************************************************
    // Frame assembly
    // ****************************************************************
    assign take_byte = rx_valid && (state_reg == S_RECV) && !take_prog;
    assign take_prog = prog_valid && prog_ready_reg;
    assign is_addr   = !can_mode && (cnt_reg == 4'h0);
    assign is_sum    = !can_mode && (cnt_reg == SER_LAST_IDX);
    assign is_last   = (cnt_reg == (can_mode ? CAN_LAST_IDX : SER_LAST_IDX));
    assign abort     = link_reset || (idle_reg == 32'(IDLE_LIMIT - 1));
    assign fire      = take_byte && is_last && !abort;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 4'h0;
        end else if (ce) begin
            if (abort) begin
                cnt_reg <= 4'h0;
            end else if (take_byte) begin
                cnt_reg <= is_last ? 4'h0 : cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_reg <= '0;
        end else if (ce) begin
            if (take_byte || cnt_reg == 4'h0 || abort) begin
                idle_reg <= '0;
            end else begin
                idle_reg <= idle_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_reg <= '0;
            sum_reg   <= 8'h00;
            mine_reg  <= 1'b0;
        end else if (ce) begin
            if (take_prog) begin
                frame_reg <= prog_cmd;
            end else if (take_byte && !abort) begin
                if (is_addr) begin
                    mine_reg <= (rx_data == node_addr);
                    sum_reg  <= rx_data;
                end else if (!is_sum) begin
                    frame_reg <= {frame_reg[47:0], rx_data};
                    sum_reg   <= sum_reg + rx_data;
                    if (can_mode && cnt_reg == 4'h0) begin
                        mine_reg <= (rx_can_id == can_node_id);
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bad_sum_reg <= 1'b0;
            host_reg    <= 1'b0;
        end else if (ce) begin
            if (take_prog) begin
                bad_sum_reg <= 1'b0;
                host_reg    <= 1'b0;
            end else if (fire) begin
                bad_sum_reg <= !can_mode && (rx_data != sum_reg);
                host_reg    <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_RECV: begin
                if (take_prog || (fire && mine_reg)) begin
                    state_next = S_EXEC;
                end
            end
            S_EXEC: begin
                state_next = host_reg ? S_REPLY : S_RECV;
            end
            S_REPLY: begin
                if (ser_done) begin
                    state_next = S_RECV;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_RECV;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // The CAN check uses the id sampled with the first byte, so a mid-frame
    // last byte is qualified by that earlier decision as well.

    // ****************************************************************
    // Command execution
    // ****************************************************************
    always_comb begin
        result = '{status: STAT_OK, instr: frame_reg.instr, value: frame_reg.value};
        wr_ok  = 1'b0;
        if (bad_sum_reg) begin
            result.status = STAT_BAD_SUM;
        end else if (frame_reg.instr == INSTR_SET_AXIS) begin
            unique case (frame_reg.typ)
                SET_MAX_SPEED, SET_MAX_ACCEL: begin
                    wr_ok = (frame_reg.value >= RAMP_MIN)
                         && (frame_reg.value <= RAMP_MAX);
                end
                SET_RUN_CUR, SET_STBY_CUR: begin
                    wr_ok = (frame_reg.value <= CURRENT_MAX);
                end
                default: begin
                    result.status = STAT_BAD_TYPE;
                end
            endcase
            if (result.status == STAT_OK && (!wr_ok || frame_reg.sel != AXIS_ZERO)) begin
                wr_ok         = 1'b0;
                result.status = STAT_BAD_VALUE;
            end
        end else if (frame_reg.instr == INSTR_GET_AXIS) begin
            result.value = 32'h0;
            unique case (frame_reg.typ)
                SET_MAX_SPEED: result.value[10:0] = set_reg.max_speed;
                SET_MAX_ACCEL: result.value[10:0] = set_reg.max_accel;
                SET_RUN_CUR:   result.value[7:0]  = set_reg.run_current;
                SET_STBY_CUR:  result.value[7:0]  = set_reg.standby_current;
                default:       result.status      = STAT_BAD_TYPE;
            endcase
        end else begin
            result.status = STAT_BAD_INSTR;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            set_reg <= '{RST_MAX_SPEED, RST_MAX_ACCEL, RST_RUN_CUR, RST_STBY_CUR};
        end else if (ce && state_reg == S_EXEC && wr_ok) begin
            unique case (frame_reg.typ)
                SET_MAX_SPEED: set_reg.max_speed       <= frame_reg.value[10:0];
                SET_MAX_ACCEL: set_reg.max_accel       <= frame_reg.value[10:0];
                SET_RUN_CUR:   set_reg.run_current     <= frame_reg.value[7:0];
                SET_STBY_CUR:  set_reg.standby_current <= frame_reg.value[7:0];
                default:       set_reg                 <= set_reg;
            endcase
        end
    end

    // ****************************************************************
    // Program-side handshake
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_ready_reg <= 1'b0;
        end else if (ce) begin
            prog_ready_reg <= (state_reg == S_RECV) && (state_next == S_RECV) && !take_prog
                           && (cnt_reg == 4'h0) && !rx_valid;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_done_reg  <= 1'b0;
            prog_reply_reg <= '0;
        end else if (ce) begin
            prog_done_reg <= (state_reg == S_EXEC) && !host_reg;
            if (state_reg == S_EXEC && !host_reg) begin
                prog_reply_reg <= result;
            end
        end
    end

    // ****************************************************************
    // Reply transmission
    // ****************************************************************
    assign ser_start = ce && (state_reg == S_EXEC) && host_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            can_id_reg <= 11'h000;
        end else if (ce && ser_start) begin
            can_id_reg <= can_node_id;
        end
    end

    reply_serializer u_reply (
        .clk        (clk),
        .arst_n     (arst_n),
        .ce         (ce),
        .start      (ser_start),
        .can_mode   (can_mode),
        .reply_addr (reply_addr),
        .node_addr  (node_addr),
        .reply      (result),
        .tx_ready   (tx_ready),
        .tx_valid   (tx_valid),
        .tx_data    (tx_data),
        .tx_last    (tx_last),
        .tx_drive   (tx_drive),
        .done       (ser_done)
    );

    assign prog_ready = prog_ready_reg;
    assign prog_done  = prog_done_reg;
    assign prog_reply = prog_reply_reg;
    assign tx_can_id  = can_id_reg;
    assign settings   = set_reg;
endmodule

// file: verif/cmd_checker_assertions.sv
/*
 * Port-level checks on the command frame interpreter.
 * Assumes a bind to the interpreter top module on its single clock.
 */
`timescale 1ns/10ps
module cmd_checker
    import cmd_pkg::*;
#(
    parameter int IDLE_LIMIT = 16
)
(
    input wire logic               clk,
    input wire logic               arst_n,
    input wire logic               ce,
    input wire logic               can_mode,
    input wire logic [7:0]         node_addr,
    input wire logic [7:0]         reply_addr,
    input wire logic [10:0]        can_node_id,
    input wire logic               link_reset,
    input wire logic               rx_valid,
    input wire logic [7:0]         rx_data,
    input wire logic [10:0]        rx_can_id,
    input wire logic               prog_valid,
    input wire cmd_pkg::cmd_t      prog_cmd,
    input wire logic               prog_ready,
    input wire logic               prog_done,
    input wire cmd_pkg::reply_t    prog_reply,
    input wire logic               tx_ready,
    input wire logic               tx_valid,
    input wire logic [7:0]         tx_data,
    input wire logic               tx_last,
    input wire logic               tx_drive,
    input wire logic [10:0]        tx_can_id,
    input wire cmd_pkg::settings_t settings
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic take;
    assign take = ce && prog_valid && prog_ready;

    a_drive_tracks_valid: assert property (tx_drive == tx_valid)
        else $error("bus driver enable differs from byte valid");
    a_last_in_reply: assert property (tx_last |-> tx_valid)
        else $error("last flag outside a reply byte");
    a_byte_held: assert property (tx_valid && !(tx_ready && ce) |=>
        tx_valid && $stable(tx_data)) else $error("reply byte dropped before accept");
    a_reply_solicited: assert property ($rose(tx_valid) |-> $past(rx_valid, 2))
        else $error("reply started without a received frame");
    a_prog_done_two: assert property (take |-> !prog_done ##2 prog_done)
        else $error("program command not finished two edges after take");
    a_ramp_nonzero: assert property (settings.max_speed != 11'h000
        && settings.max_accel != 11'h000) else $error("ramp setting reached zero");
    a_settings_cause: assert property ($changed(settings) |->
        $past(rx_valid, 2) || $past(take, 2)) else $error("setting moved without command");
    a_can_reply_id: assert property (tx_valid && can_mode |->
        tx_can_id == can_node_id) else $error("reply id differs from own id");

    cover property (tx_last && tx_ready && !can_mode);
    cover property (tx_last && tx_ready && can_mode);
    cover property (prog_done);
endmodule

// file: verif/host_model.sv
/*
 * Host bus master model: sends command frames and collects replies.
 * Assumes the interpreter's byte handshake on the same clock.
 */
`timescale 1ns/10ps
module host_model
    import cmd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            tx_ready
);
    logic       slow = 1'b0;
    logic [7:0] rep[$];

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end

    // A released data line shows the inverse of its last byte.
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge clk);
            #1;
            rx_valid = 1'b1;
            rx_data  = b[i];
        end
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask

    task automatic frame(input logic can, input logic [7:0] addr, input cmd_t c,
                         input logic [7:0] sum_err);
        logic [7:0] b[$];
        logic [7:0] s;
        logic       fin;
        if (!can) b.push_back(addr);
        for (int i = 6; i >= 0; i--) b.push_back(c[8*i +: 8]);
        s = sum_err;
        foreach (b[i]) s += b[i];
        if (!can) b.push_back(s);
        send(b);
        rep = {};
        fin = 1'b0;
        for (int n = 0; n < 60 && !fin; n++) begin
            @(posedge clk);
            if (tx_valid && tx_ready) begin
                rep.push_back(tx_data);
                fin = tx_last;
            end
            #1;
            tx_ready = !fin && (slow ? !tx_ready : 1'b1);
        end
    endtask
endmodule

// file: verif/serial_command_frame_interpreter_tb.sv
/*
 * Self-checking bench for the command frame interpreter.
 * Assumes the host model, the checker and the design package.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module serial_command_frame_interpreter_tb;
    import cmd_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, can_mode = 1'b0, link_reset = 1'b0;
    logic prog_valid = 1'b0, rx_valid, tx_ready, prog_ready, prog_done;
    logic tx_valid, tx_last, tx_drive;
    logic [7:0] rx_data, tx_data, node_addr = 8'h01, reply_addr = 8'h02;
    logic [10:0] can_node_id = 11'h0a5, rx_can_id = 11'h0a5, tx_can_id;
    cmd_t prog_cmd = '0;
    reply_t prog_reply;
    settings_t settings;
    int errors = 0, num_checks = 0;
    logic [7:0] wt[4] = '{8'h04, 8'h05, 8'h06, 8'h07};
    logic [31:0] wv[4] = '{32'h7ff, 32'h1, 32'hff, 32'h0};
    cmd_t ec[6] = '{'{8'h05, 8'h04, 8'h00, 32'h10}, '{8'h01, 8'h04, 8'h00, 32'h1},
        '{8'h05, 8'h09, 8'h00, 32'h1}, '{8'h05, 8'h04, 8'h00, 32'h0},
        '{8'h05, 8'h06, 8'h00, 32'h100}, '{8'h05, 8'h05, 8'h01, 32'h2}};
    logic [7:0] es[6] = '{STAT_BAD_SUM, STAT_BAD_INSTR, STAT_BAD_TYPE, STAT_BAD_VALUE,
        STAT_BAD_VALUE, STAT_BAD_VALUE};

    always #10 clk = ~clk;

    serial_command_frame_interpreter #(.IDLE_LIMIT(16)) u_dut (.*);
    host_model u_host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));

    // ****************************************************************
    // Frame exchange and verdict
    // ****************************************************************
    task automatic run(input logic cm, input logic [7:0] addr, input cmd_t c,
                       input logic [7:0] serr, input logic [7:0] st, input logic [31:0] v,
                       input bit answer);
        logic [7:0] e[$];
        logic [7:0] s;
        u_host.frame(cm, addr, c, serr);
        if (answer) begin
            if (!cm) e.push_back(reply_addr);
            e = {e, node_addr, st, c.instr, v[31:24], v[23:16], v[15:8], v[7:0]};
            s = 8'h00;
            foreach (e[i]) s += e[i];
            if (!cm) e.push_back(s);
        end
        `CHK("reply_len", e.size(), u_host.rep.size())
        foreach (e[i]) `CHK("reply_byte", e[i], u_host.rep[i])
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        `CHK("settings_rst", {RST_MAX_SPEED, RST_MAX_ACCEL, RST_RUN_CUR, RST_STBY_CUR}, settings)
        for (int k = 0; k < 4; k++) begin
            u_host.slow = k[0];
            run(0, 8'h01, '{INSTR_SET_AXIS, wt[k], 8'h00, wv[k]}, 0, STAT_OK, wv[k], 1);
            run(0, 8'h01, '{INSTR_GET_AXIS, wt[k], 8'h00, 0}, 0, STAT_OK, wv[k], 1);
        end
        for (int k = 0; k < 6; k++)
            run(0, 8'h01, ec[k], {7'h0, k == 0}, es[k], ec[k].value, 1);
        run(0, 8'h03, '{INSTR_SET_AXIS, 8'h04, 8'h00, 32'h5}, 0, 0, 0, 0);
        `CHK("settings_kept", 38'({11'h7ff, 11'h001, 8'hff, 8'h00}), settings)
        can_mode = 1'b1;
        run(1, 0, '{INSTR_SET_AXIS, 8'h06, 8'h00, 32'h40}, 0, STAT_OK, 32'h40, 1);
        rx_can_id = 11'h0a6;
        run(1, 0, '{INSTR_SET_AXIS, 8'h06, 8'h00, 32'h41}, 0, 0, 0, 0);
        can_mode = 1'b0;
        u_host.send({8'h01, 8'h05, 8'h04});
        link_reset = 1'b1;
        @(posedge clk);
        #1 link_reset = 1'b0;
        run(0, 8'h01, '{INSTR_SET_AXIS, 8'h04, 8'h00, 32'h64}, 0, STAT_OK, 32'h64, 1);
        u_host.send({8'h01, 8'h05});
        repeat (20) @(posedge clk);
        run(0, 8'h01, '{INSTR_SET_AXIS, 8'h05, 8'h00, 32'h7}, 0, STAT_OK, 32'h7, 1);
        prog_cmd = '{INSTR_SET_AXIS, SET_STBY_CUR, 8'h00, 32'h11};
        prog_valid = 1'b1;
        for (int n = 0; n < 20 && !prog_ready; n++) @(posedge clk) #1;
        `CHK("prog_ready", 1'b1, prog_ready)
        @(posedge clk);
        #1 prog_valid = 1'b0;
        @(posedge clk);
        #1 `CHK("prog_done", 1'b1, prog_done)
        `CHK("prog_reply", {STAT_OK, INSTR_SET_AXIS, 32'h11}, prog_reply)
        `CHK("standby_cur", 8'h11, settings.standby_current)
        `CHK("run_cur", 8'h40, settings.run_current)
        end_of_test();
    end
endmodule

bind serial_command_frame_interpreter cmd_checker #(.IDLE_LIMIT(IDLE_LIMIT)) u_chk (.*);
